// [common/serial_err_cfg.svh]
// Offsets, field positions, codes and timing counts for the error/timing block
// Assumes a 200 MHz pclk and a 32-bit APB register bus
`ifndef SERIAL_ERR_CFG_SVH
`define SERIAL_ERR_CFG_SVH

`define CLK_MHZ          200
`define TURN_MAX_MS      5
`define BREAK_UNIT_S     1
`define TX_ERR_LIMIT     4'h8

`define OFF_CTRL         12'h000
`define OFF_BREAK_TIME   12'h004
`define OFF_STATUS       12'h008

`define CTRL_ROUTE_LSB   0
`define CTRL_PORT_SEL    2
`define BRK_ONE_LSB      0
`define BRK_TWO_LSB      8
`define ST_CODE_LSB      0
`define ST_COUNT_LSB     8
`define ST_COMM_ERR      16
`define ST_IN_BREAK      17
`define ST_SEEN_VALID    18

`define ERR_CHECKSUM     8'h47
`define ERR_PARITY       8'h48
`define ERR_RX_OTHER     8'h49
`define ERR_FORMAT       8'h4a
`define ERR_COMMAND      8'h4b
`define ERR_ROUTE        8'h4c
`define ERR_FUNC_CODE    8'h4e
`define ERR_WRITE_LOCK   8'h4f
`define ERR_DATA         8'h50
`define ERR_BUSY_WRITE   8'h51

`endif

// [common/serial_err_pkg.sv]
// Shared types of the error/timing block
// Assumes serial_err_cfg.svh supplies every number
package serial_err_pkg;
  typedef enum logic [1:0] {
    ST_LISTEN,
    ST_REPLY,
    ST_TURN
  } fsm_t;
  typedef logic [7:0] err_code_t;
  typedef logic [6:0] logic_faults_t;
endpackage

// [common/fault_link_if.sv]
// Carrier between the frame checker, the fault picker and the break timer
// Assumes all parties run on pclk
`timescale 1ns/100ps
interface fault_link_if;
  serial_err_pkg::logic_faults_t faults;
  serial_err_pkg::err_code_t     pick_code;
  logic                          pick_any;
  logic                          armed;
  logic                          valid_seen;
  logic [5:0]                    setting;
  logic                          trip;
  logic                          in_break;
  modport pick_mp (input faults, output pick_code, output pick_any);
  modport timer_mp (input armed, input valid_seen, input setting,
                    output trip, output in_break);
  modport ctrl_mp (output faults, input pick_code, input pick_any,
                   output armed, output valid_seen, output setting,
                   input trip, input in_break);
endinterface // fault_link_if

// [core/logical_error_pick.sv]
// Picks the logical fault with the smallest priority number
// Assumes faults[0] is priority 1 and faults[6] priority 7
`timescale 1ns/100ps
`include "serial_err_cfg.svh"
module logical_error_pick (
  // Fault flags in, code out
  fault_link_if.pick_mp lnk
);
  always_comb begin
    lnk.pick_any  = |lnk.faults;
    lnk.pick_code = 8'h00;
    casez (lnk.faults)
      7'b??????1: lnk.pick_code = `ERR_FORMAT;
      7'b?????10: lnk.pick_code = `ERR_COMMAND;
      7'b????100: lnk.pick_code = `ERR_ROUTE;
      7'b???1000: lnk.pick_code = `ERR_FUNC_CODE;
      7'b??10000: lnk.pick_code = `ERR_WRITE_LOCK;
      7'b?100000: lnk.pick_code = `ERR_DATA;
      7'b1000000: lnk.pick_code = `ERR_BUSY_WRITE;
      default:    lnk.pick_code = 8'h00;
    endcase
  end
endmodule // logical_error_pick

// [core/link_break_timer.sv]
// Times a link break in whole seconds and flags when it outlasts the setting
// Assumes armed and valid_seen come from logic on pclk
`timescale 1ns/100ps
`include "serial_err_cfg.svh"
module link_break_timer #(
  parameter int unsigned SEC_CYC = `BREAK_UNIT_S * `CLK_MHZ * 1000000
) (
  // Clock and reset
  input  wire logic     pclk,
  input  wire logic     presetn,
  // Break supervision
  fault_link_if.timer_mp lnk
);
  typedef struct packed {
    logic [31:0] pre;
    logic [5:0]  secs;
    logic        tripped;
    logic        trip;
  } tstate_t;
  tstate_t s, next_s;

  assign lnk.trip     = s.trip;
  assign lnk.in_break = lnk.armed;

  always_comb begin
    next_s      = s;
    next_s.trip = 1'b0;
    if (!lnk.armed || lnk.valid_seen || lnk.setting == 6'h00) begin
      next_s = '0;
    end else if (!s.tripped) begin
      if (s.pre == SEC_CYC - 1) begin
        next_s.pre  = '0;
        next_s.secs = s.secs + 6'h01;
        if (s.secs + 6'h01 >= lnk.setting) begin
          next_s.trip    = 1'b1;
          next_s.tripped = 1'b1;
        end
      end else begin
        next_s.pre = s.pre + 32'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule // link_break_timer

// [core/serial_slave_error_timing.sv]
// Slave-station error sorting, reply decision and line turnaround
// Assumes frame checks arrive as one-cycle flags from a receiver on pclk
//
// What this block does
// - Back to receive within 5 ms
// - Broadcast: execute, no reply, keep receiving
// - Local checksum mismatch records code 71
// - Parity mismatch records code 72
// - Framing or overrun records code 73
// - Bad characters or end: code 74, first
// - Undefined command letter: code 75, second
// - Command write via wrong route: 76, third
// - Missing function code: code 78, fourth
// - Write to locked code: 79, fifth
// - Write value out of range: 80
// - Write during high-speed write: 81
// - No reply on transmission error; eight escalate
// - Valid frame clears the error count
// - Logical error answers NAK, smallest priority
// - No end-of-text by byte 15: silence
// - Break needs serial run and seen frame
// - Break beyond set seconds is comm error
// - Break timer cleared outside break
// - Latest error code readable by host
`timescale 1ns/100ps
`include "serial_err_cfg.svh"
module serial_slave_error_timing #(
  parameter int unsigned TURN_CYC = `TURN_MAX_MS * `CLK_MHZ * 1000,
  parameter int unsigned SEC_CYC  = `BREAK_UNIT_S * `CLK_MHZ * 1000000
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Frame checks from the receiver, valid with frame_end
  input  wire logic        frame_end,
  input  wire logic        frame_local,
  input  wire logic        frame_bcast,
  input  wire logic        rx_checksum_bad,
  input  wire logic        rx_parity_bad,
  input  wire logic        rx_other_bad,
  input  wire logic        etx_missing,
  input  wire logic        req_format_bad,
  input  wire logic        req_cmd_bad,
  input  wire logic        req_is_write,
  input  wire logic        req_link_target,
  input  wire logic [1:0]  req_route,
  input  wire logic        req_func_missing,
  input  wire logic        req_write_locked,
  input  wire logic        req_data_range,
  input  wire logic        hs_write_busy,
  // Drive state
  input  wire logic        run_active,
  input  wire logic        serial_cmd_mode,
  // Transmitter
  input  wire logic        tx_done,
  output logic             reply_start,
  output logic             reply_nak,
  output logic [7:0]       reply_code,
  output logic             line_drive,
  output logic             rx_enable,
  // Command execution and alarm
  output logic             exec_start,
  output logic             comm_error
);
  typedef struct packed {
    // Sequencing and error record
    serial_err_pkg::fsm_t      st;
    logic [31:0]               turn;
    logic [3:0]                txerr;
    logic                      seen;
    serial_err_pkg::err_code_t code;
    logic                      comm_err;
    // Software settings
    logic [1:0]                route;
    logic                      port_two;
    logic [5:0]                brk_one;
    logic [5:0]                brk_two;
    // Bus answer
    logic                      pready;
    logic                      pslverr;
    logic [31:0]               prdata;
    // Transmitter and execution controls
    logic                      reply_start;
    logic                      reply_nak;
    serial_err_pkg::err_code_t reply_code;
    logic                      exec_start;
    logic                      line_drive;
    logic                      rx_enable;
  } state_t;

  state_t s;
  state_t next_s;

  // Last turnaround count, cut to the counter's width
  localparam logic [31:0] TURN_LAST = 32'(TURN_CYC - 1);

  // Sub-blocks
  fault_link_if lnk ();

  logical_error_pick u_pick (
    .lnk (lnk.pick_mp)
  );

  link_break_timer #(
    .SEC_CYC (SEC_CYC)
  ) u_break (
    .pclk    (pclk),
    .presetn (presetn),
    .lnk     (lnk.timer_mp)
  );

  // Frames meant for this station, singly or by broadcast
  function automatic logic for_us(input logic local_hit, input logic bcast_hit);
    for_us = local_hit || bcast_hit;
  endfunction

  // Frame classification
  logic        accept;
  logic        cks_err;
  logic        tx_err;
  logic        etx_drop;
  logic        good_frame;
  logic        route_err;
  logic [7:0]  tx_code;
  logic        limit_hit;

  assign accept    = frame_end && s.st == serial_err_pkg::ST_LISTEN;
  // Checksum only counts against frames meant for this station
  assign cks_err   = rx_checksum_bad && for_us(frame_local, frame_bcast);
  assign tx_err    = accept && (cks_err || rx_parity_bad || rx_other_bad);
  // An unterminated frame is dropped unanswered and proves nothing
  assign etx_drop  = accept && !tx_err && etx_missing;
  // A clean frame for any station proves the link is alive
  assign good_frame = accept && !tx_err && !etx_drop;
  assign route_err = req_is_write && req_link_target
                     && req_route != s.route;
  // Eighth damaged frame in a row
  assign limit_hit = s.txerr == `TX_ERR_LIMIT - 4'h1;

  always_comb begin
    if (rx_parity_bad) begin
      tx_code = `ERR_PARITY;
    end else if (cks_err) begin
      tx_code = `ERR_CHECKSUM;
    end else begin
      tx_code = `ERR_RX_OTHER;
    end
  end

  assign lnk.faults = {
    req_is_write && hs_write_busy,
    req_is_write && req_data_range,
    req_is_write && req_write_locked,
    req_func_missing,
    route_err,
    req_cmd_bad,
    req_format_bad
  };
  assign lnk.armed      = run_active && serial_cmd_mode && s.seen;
  assign lnk.valid_seen = good_frame;
  assign lnk.setting    = s.port_two ? s.brk_two : s.brk_one;

  // Register bus decode
  logic        apb_first;
  logic        apb_go;
  logic        apb_wr;
  logic        hit_ctrl;
  logic        hit_brk;
  logic        hit_stat;
  logic        hit;
  logic [31:0] rd_word;

  // First access cycle; the answer follows one cycle later
  assign apb_first = psel && penable && !s.pready;
  assign apb_go    = psel && penable && s.pready;
  assign apb_wr    = apb_go && pwrite && !s.pslverr;
  assign hit_ctrl  = paddr == `OFF_CTRL;
  assign hit_brk   = paddr == `OFF_BREAK_TIME;
  assign hit_stat  = paddr == `OFF_STATUS;
  assign hit       = hit_ctrl || hit_brk || hit_stat;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      `OFF_CTRL: begin
        rd_word[`CTRL_ROUTE_LSB +: 2] = s.route;
        rd_word[`CTRL_PORT_SEL]       = s.port_two;
      end
      `OFF_BREAK_TIME: begin
        rd_word[`BRK_ONE_LSB +: 6] = s.brk_one;
        rd_word[`BRK_TWO_LSB +: 6] = s.brk_two;
      end
      `OFF_STATUS: begin
        rd_word[`ST_CODE_LSB +: 8]  = s.code;
        rd_word[`ST_COUNT_LSB +: 4] = s.txerr;
        rd_word[`ST_COMM_ERR]       = s.comm_err;
        rd_word[`ST_IN_BREAK]       = lnk.in_break;
        rd_word[`ST_SEEN_VALID]     = s.seen;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    logic set_err;
    logic clr_err;
    set_err = 1'b0;
    clr_err = 1'b0;
    next_s  = s;
    next_s.reply_start = 1'b0;
    next_s.exec_start  = 1'b0;

    // One wait state: answer on the second access cycle
    next_s.pready  = apb_first;
    // Unmapped offsets answer with an error and never write
    next_s.pslverr = apb_first && !hit;
    if (apb_first) begin
      if (hit) begin
        next_s.prdata = rd_word;
      end else begin
        next_s.prdata = 32'h0000_0000;
      end
    end
    if (apb_wr) begin
      case (paddr)
        `OFF_CTRL: begin
          next_s.route    = pwdata[`CTRL_ROUTE_LSB +: 2];
          next_s.port_two = pwdata[`CTRL_PORT_SEL];
        end
        `OFF_BREAK_TIME: begin
          next_s.brk_one = pwdata[`BRK_ONE_LSB +: 6];
          next_s.brk_two = pwdata[`BRK_TWO_LSB +: 6];
        end
        `OFF_STATUS: clr_err = pwdata[`ST_COMM_ERR];
        default: clr_err = 1'b0;
      endcase
    end

    // Any clean frame ends a run of damaged ones
    if (good_frame) begin
      next_s.txerr = 4'h0;
      next_s.seen  = 1'b1;
    end

    // Listen, drive the reply, then turn the line round
    case (s.st)
      serial_err_pkg::ST_LISTEN: begin
        next_s.rx_enable  = 1'b1;
        next_s.line_drive = 1'b0;
        if (tx_err) begin
          // Silent so stations never talk over each other
          next_s.code = tx_code;
          if (limit_hit) begin
            set_err      = 1'b1;
            next_s.txerr = 4'h0;
          end else begin
            next_s.txerr = s.txerr + 4'h1;
          end
        end else if (good_frame && for_us(frame_local, frame_bcast)) begin
          if (lnk.pick_any) begin
            next_s.code = lnk.pick_code;
          end
          if (frame_bcast) begin
            next_s.exec_start = !lnk.pick_any;
          end else begin
            next_s.exec_start  = !lnk.pick_any;
            next_s.reply_start = 1'b1;
            next_s.reply_nak   = lnk.pick_any;
            next_s.reply_code  = lnk.pick_any ? lnk.pick_code : 8'h00;
            next_s.line_drive  = 1'b1;
            next_s.rx_enable   = 1'b0;
            next_s.st          = serial_err_pkg::ST_REPLY;
          end
        end
        // Missing end-of-text falls through here with no reply
      end
      serial_err_pkg::ST_REPLY: begin
        if (tx_done) begin
          // Driver off at once; the turnaround count starts here
          next_s.line_drive = 1'b0;
          next_s.turn       = 32'h0;
          next_s.st         = serial_err_pkg::ST_TURN;
        end
      end
      serial_err_pkg::ST_TURN: begin
        // Bounded by the 5 ms ceiling; the host waits longer than this
        if (s.turn >= TURN_LAST) begin
          next_s.rx_enable = 1'b1;
          next_s.st        = serial_err_pkg::ST_LISTEN;
        end else begin
          next_s.turn = s.turn + 32'h1;
        end
      end
      default: begin
        next_s.st         = serial_err_pkg::ST_LISTEN;
        next_s.line_drive = 1'b0;
        next_s.rx_enable  = 1'b1;
      end
    endcase

    // Link-break escalation from the timer
    if (lnk.trip) begin
      set_err = 1'b1;
    end
    // A new error wins over a software clear in the same cycle
    next_s.comm_err = (s.comm_err && !clr_err) || set_err;
  end

  // Reset leaves the receiver on so the first frame is heard
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s           <= '0;
      s.st        <= serial_err_pkg::ST_LISTEN;
      s.rx_enable <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Every output comes straight from a state flop
  assign pready      = s.pready;
  assign prdata      = s.prdata;
  assign pslverr     = s.pslverr;
  assign reply_start = s.reply_start;
  assign reply_nak   = s.reply_nak;
  assign reply_code  = s.reply_code;
  assign line_drive  = s.line_drive;
  assign rx_enable   = s.rx_enable;
  assign exec_start  = s.exec_start;
  assign comm_error  = s.comm_err;
endmodule // serial_slave_error_timing

// [dv/host_link_model.sv]
// Far side of the reply path: transmitter finish and host pacing
// Assumes reply_start is a one-cycle pulse on pclk
`timescale 1ns/100ps
module host_link_model #(
  parameter int unsigned TX_CYC = 6
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Device side
  input  wire logic reply_start,
  input  wire logic rx_enable,
  output logic      tx_done,
  // Host side
  output logic      may_send
);
  int unsigned left;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= 0;
      tx_done <= 1'b0;
      may_send <= 1'b0;
    end else begin
      tx_done <= (left == 1);
      if (reply_start) begin
        left <= TX_CYC;
      end else if (left != 0) begin
        left <= left - 1;
      end
      // One cycle past receive-ready, so the gap is strictly longer
      may_send <= rx_enable;
    end
  end
endmodule // host_link_model

// [dv/serial_slave_error_timing_properties.sv]
// Port-level checks of the slave error/timing block
// Assumes binding onto serial_slave_error_timing
`timescale 1ns/100ps
module serial_err_checker #(
  parameter int unsigned TURN_CYC = 20
) (
  // Clock and reset
  input wire logic        pclk, presetn,
  // APB
  input wire logic        psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // Frame checks
  input wire logic        frame_end, frame_local, frame_bcast, rx_checksum_bad,
  input wire logic        rx_parity_bad, rx_other_bad, etx_missing, req_format_bad,
  // Reply side
  input wire logic        tx_done, reply_start, reply_nak, line_drive, rx_enable,
  input wire logic        exec_start, comm_error,
  input wire logic [7:0]  reply_code
);
  logic [31:0] gap;
  logic        take, txe, w1c;
  assign take = frame_end && rx_enable && !line_drive;
  assign txe = rx_parity_bad || rx_other_bad || rx_checksum_bad;
  assign w1c = psel && penable && pready && pwrite && paddr == 12'h008 && pwdata[16];
  // Cycles with neither driver nor receiver on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap <= 32'h0;
    else if (!rx_enable && !line_drive) gap <= gap + 32'h1;
    else gap <= 32'h0;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_turn_exact: assert property ($rose(rx_enable) |-> gap == TURN_CYC)
    else $error("receiver ready at wrong cycle");
  chk_turn_bound: assert property (gap <= TURN_CYC)
    else $error("turnaround too long");
  chk_drive_drop: assert property (tx_done && line_drive |=> !line_drive)
    else $error("driver held after send");
  chk_reply_drive: assert property (reply_start |-> line_drive && !rx_enable)
    else $error("reply without driver");
  chk_txerr_silent: assert property (take && txe |=> !reply_start && !exec_start)
    else $error("answered a damaged frame");
  chk_bcast_silent: assert property (take && frame_bcast |=> !reply_start && !line_drive)
    else $error("answered a broadcast");
  chk_etx_silent: assert property (take && frame_local && !txe && etx_missing
    |=> !reply_start && !exec_start)
    else $error("answered frame without end");
  chk_format_nak: assert property (take && frame_local && !frame_bcast && !txe && !etx_missing
    && req_format_bad |=> reply_start && reply_nak && reply_code == 8'h4a)
    else $error("format fault not refused");
  chk_apb_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("bus answer late");
  chk_apb_unmapped: assert property (pready && psel && paddr > 12'h008
    |-> pslverr && prdata == 32'h0)
    else $error("unmapped access accepted");
  chk_err_sticky: assert property (comm_error && !w1c |=> comm_error)
    else $error("error flag dropped");
endmodule // serial_err_checker

bind serial_slave_error_timing serial_err_checker #(.TURN_CYC(TURN_CYC)) u_serial_err_checker (
  .pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata,
  .frame_end, .frame_local, .frame_bcast, .rx_checksum_bad, .rx_parity_bad, .rx_other_bad,
  .etx_missing, .req_format_bad, .tx_done, .reply_start, .reply_nak, .line_drive, .rx_enable,
  .exec_start, .comm_error, .reply_code);

// [dv/tb_top.sv]
// Self-checking bench for the slave error/timing block
// Assumes shortened turnaround and one-second counts
`timescale 1ns/100ps
module tb_top;
  localparam int unsigned TURN = 20;
  localparam int unsigned SEC  = 50;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, may_send;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata, resp;
  logic        frame_end, frame_local, frame_bcast, rx_checksum_bad, rx_parity_bad;
  logic        rx_other_bad, etx_missing, req_format_bad, req_cmd_bad, req_is_write;
  logic        req_link_target, req_func_missing, req_write_locked, req_data_range;
  logic        hs_write_busy, run_active, serial_cmd_mode, tx_done, reply_start;
  logic        reply_nak, line_drive, rx_enable, exec_start, comm_error;
  logic [1:0]  req_route;
  logic [7:0]  reply_code;
  logic [13:0] fr, m;
  int          failures, check_count, cyc, n, i;
  // Single logical faults in priority order, and their codes
  logic [13:0] lf [7] = '{14'h0080, 14'h0040, 14'h0030, 14'h0008, 14'h0024, 14'h0022, 14'h0021};
  logic [7:0]  lc [7] = '{8'h4a, 8'h4b, 8'h4c, 8'h4e, 8'h4f, 8'h50, 8'h51};
  logic [13:0] tf [3] = '{14'h2400, 14'h2800, 14'h2200};
  logic [7:0]  tc [3] = '{8'h48, 8'h47, 8'h49};
  assign {frame_local, frame_bcast, rx_checksum_bad, rx_parity_bad, rx_other_bad, etx_missing,
    req_format_bad, req_cmd_bad, req_is_write, req_link_target, req_func_missing,
    req_write_locked, req_data_range, hs_write_busy} = fr;

  serial_slave_error_timing #(.TURN_CYC(TURN), .SEC_CYC(SEC)) u_serial_slave_error_timing (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .frame_end, .frame_local, .frame_bcast, .rx_checksum_bad, .rx_parity_bad, .rx_other_bad,
    .etx_missing, .req_format_bad, .req_cmd_bad, .req_is_write, .req_link_target, .req_route,
    .req_func_missing, .req_write_locked, .req_data_range, .hs_write_busy, .run_active,
    .serial_cmd_mode, .tx_done, .reply_start, .reply_nak, .reply_code, .line_drive,
    .rx_enable, .exec_start, .comm_error);
  host_link_model u_host_link_model (.pclk, .presetn, .reply_start, .rx_enable, .tx_done,
    .may_send);

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; returns just after one, bus idle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer taken at the very edge that sees pready high
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic frame(input logic [13:0] f, input logic [1:0] rt);
    do begin
      @(negedge pclk);
    end while (!(rx_enable === 1'b1 && may_send === 1'b1));
    @(posedge pclk);
    fr <= f;
    req_route <= rt;
    frame_end <= 1'b1;
    @(posedge pclk);
    frame_end <= 1'b0;
    fr <= 14'h0;
    @(negedge pclk);
    resp = {21'h0, reply_start, exec_start, reply_start ? {reply_nak, reply_code} : 9'h000};
    @(posedge pclk);
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, frame_end, run_active, serial_cmd_mode} = 7'h0;
    {paddr, pwdata, req_route, fr} = 60'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 3; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      check(rdata, 32'h0);
      check(rerr, 1'b0);
    end
    apb(1'b0, 12'h00c, 32'h0);
    check({rerr, rdata[30:0]}, 32'h80000000);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    check(rdata, 32'h1);
    $display("register test done");
    frame(14'h2000, 2'h0);
    check(resp, 32'h600);
    n = 0;
    while (line_drive !== 1'b0 && n < 100) begin
      @(negedge pclk);
      n++;
    end
    n = 0;
    while (rx_enable !== 1'b1 && n < 100) begin
      n++;
      @(negedge pclk);
    end
    check(n, TURN);
    @(posedge pclk);
    $display("turnaround test done");
    m = 14'h0;
    for (i = 6; i >= 0; i--) begin
      m = m | lf[i];
      frame(14'h2000 | lf[i], 2'h0);
      check(resp, {21'h0, 3'b101, lc[i]});
      apb(1'b0, 12'h008, 32'h0);
      check(rdata[7:0], lc[i]);
      frame(14'h2000 | m, 2'h0);
      check(resp, {21'h0, 3'b101, lc[i]});
    end
    $display("logical error test done");
    for (i = 0; i < 3; i++) begin
      frame(tf[i], 2'h0);
      check(resp, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      check(rdata[11:0], {4'(i + 1), tc[i]});
    end
    frame(14'h0000, 2'h0);
    apb(1'b0, 12'h008, 32'h0);
    check(rdata[11:8], 4'h0);
    for (i = 0; i < 8; i++) begin
      check(comm_error, 1'b0);
      frame(14'h0400, 2'h0);
    end
    @(negedge pclk);
    check(comm_error, 1'b1);
    @(posedge pclk);
    apb(1'b1, 12'h008, 32'h10000);
    apb(1'b0, 12'h008, 32'h0);
    check(rdata[16:8], 9'h0);
    frame(14'h1000, 2'h0);
    check(resp, 32'h200);
    check(rx_enable, 1'b1);
    repeat (10) @(posedge pclk);
    frame(14'h0400, 2'h0);
    frame(14'h2100, 2'h0);
    check(resp, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    check(rdata[11:8], 4'h1);
    $display("transmission error test done");
    apb(1'b1, 12'h004, 32'h200);
    apb(1'b1, 12'h000, 32'h5);
    apb(1'b0, 12'h004, 32'h0);
    check(rdata, 32'h200);
    run_active <= 1'b1;
    serial_cmd_mode <= 1'b1;
    frame(14'h0000, 2'h0);
    repeat (80) @(posedge pclk);
    frame(14'h0000, 2'h0);
    repeat (90) @(posedge pclk);
    @(negedge pclk);
    check(comm_error, 1'b0);
    @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0);
    check(rdata[18:17], 2'b11);
    repeat (30) @(posedge pclk);
    @(negedge pclk);
    check(comm_error, 1'b1);
    @(posedge pclk);
    $display("link break test done");
    give_verdict();
  end
endmodule // tb_top
